// [verilog/iowl_pkg.sv]
// shared constants for the i/o window limit register bank
package iowl_pkg;
    localparam int          APB_AW        = 12;
    localparam int          NUM_WIN       = 2;
    localparam int          NUM_HALF      = 8;
    localparam int          IDX_LSB       = 2;
    localparam int          IDX_MSB       = 9;
    // register indices; byte address is four times the index
    localparam logic [7:0]  IDX_W0_BOT_LO = 8'h2C;
    localparam logic [7:0]  IDX_W0_BOT_HI = 8'h2E;
    localparam logic [7:0]  IDX_W0_TOP_LO = 8'h30;
    localparam logic [7:0]  IDX_W0_TOP_HI = 8'h32;
    localparam logic [7:0]  IDX_W1_BOT_LO = 8'h34;
    localparam logic [7:0]  IDX_W1_BOT_HI = 8'h36;
    localparam logic [7:0]  IDX_W1_TOP_LO = 8'h38;
    localparam logic [7:0]  IDX_W1_TOP_HI = 8'h3A;
    localparam logic [7:0]  IDX_IRQ_ROUTE = 8'h3C;
    localparam logic [7:0]  IDX_CTRL      = 8'h40;
    localparam logic [7:0]  IDX_STATUS    = 8'h41;
    // half-register order: window, then bottom/top, then low/high
    localparam logic [7:0]  HALF_IDX [NUM_HALF] = '{
        IDX_W0_BOT_LO, IDX_W0_BOT_HI, IDX_W0_TOP_LO, IDX_W0_TOP_HI,
        IDX_W1_BOT_LO, IDX_W1_BOT_HI, IDX_W1_TOP_LO, IDX_W1_TOP_HI};
    localparam logic [15:0] HALF_RESET    = 16'h0000;
    localparam logic [15:0] LOW_WMASK     = 16'hFFFC;
    localparam logic [15:0] HIGH_WMASK    = 16'hFFFF;
    localparam logic [1:0]  MODE_16       = 2'h0;
    localparam logic [1:0]  MODE_32       = 2'h1;
    localparam logic [1:0]  LIMIT_LOW     = 2'h3;
    localparam logic [1:0]  BASE_LOW      = 2'h0;
    localparam logic [7:0]  IRQ_RESET     = 8'h00;
    localparam int          CTRL_IO_EN    = 0;
    localparam int          CTRL_CARD_CB  = 1;
    localparam logic [1:0]  CTRL_RESET    = 2'h0;
endpackage : iowl_pkg

// [verilog/iowl_half_reg.sv]
// one 16-bit half of a window bound register with a fixed writable mask
`timescale 1ns/1ps
module iowl_half_reg #(
    parameter logic [15:0] WMASK = 16'hFFFF
) (
    input  wire logic        clk_i,
    input  wire logic        reset_i,
    input  wire logic        wr_i,
    input  wire logic [1:0]  be_i,
    input  wire logic [15:0] wdata_i,
    output logic      [15:0] q_o
);
    logic [15:0] lane_mask;
    logic [15:0] next_q;

    assign lane_mask = WMASK & {{8{be_i[1]}}, {8{be_i[0]}}};
    // bits outside the mask never change, so read-only bits stay zero
    assign next_q    = (q_o & ~lane_mask) | (wdata_i & lane_mask);

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            q_o <= iowl_pkg::HALF_RESET;
        else if (wr_i)
            q_o <= next_q;
    end
endmodule : iowl_half_reg

// [verilog/iowl_win_cmp.sv]
// inclusive base/limit compare for one i/o window
`timescale 1ns/1ps
module iowl_win_cmp (
    input  wire logic        mode32_i,
    input  wire logic [31:0] addr_i,
    input  wire logic [15:0] bot_lo_i,
    input  wire logic [15:0] bot_hi_i,
    input  wire logic [15:0] top_lo_i,
    input  wire logic [15:0] top_hi_i,
    output logic      [31:0] bot_o,
    output logic      [31:0] top_o,
    output logic             hit_o
);
    logic [15:0] bot_upper;
    logic [15:0] top_upper;

    assign bot_upper = mode32_i ? bot_hi_i : 16'h0000;
    assign top_upper = mode32_i ? top_hi_i : 16'h0000;
    assign bot_o     = {bot_upper, bot_lo_i[15:2], iowl_pkg::BASE_LOW};
    // limit covers the whole doubleword it names
    assign top_o     = {top_upper, top_lo_i[15:2], iowl_pkg::LIMIT_LOW};
    // limit below base gives an empty window
    assign hit_o     = (addr_i >= bot_o) && (addr_i <= top_o);
endmodule : iowl_win_cmp

// [verilog/iowl_regs.sv]
// i/o window base/limit and interrupt routing registers over apb
//
// The APB register port is this design's own decision.
`timescale 1ns/1ps
module iowl_regs #(
    parameter bit IO_ADDR_32 = 1'b1
) (
    input  wire logic                        CLK_I,
    input  wire logic                        RESET_I,
    input  wire logic                        PSEL_I,
    input  wire logic                        PENABLE_I,
    input  wire logic                        PWRITE_I,
    input  wire logic [iowl_pkg::APB_AW-1:0] PADDR_I,
    input  wire logic [31:0]                 PWDATA_I,
    input  wire logic [3:0]                  PSTRB_I,
    output logic      [31:0]                 PRDATA_O,
    output logic                             PREADY_O,
    output logic                             PSLVERR_O,
    input  wire logic                        IO_REQ_I,
    input  wire logic [31:0]                 IO_ADDR_I,
    output logic                             FWD_O,
    output logic      [iowl_pkg::NUM_WIN-1:0] FWD_WIN_O,
    output logic      [7:0]                  IRQ_ROUTE_O
);
    logic [7:0]  reg_idx;
    logic        setup_rd;
    logic        access;
    logic        wr_access;
    logic [1:0]  mode_bits;
    logic [15:0] half_q    [iowl_pkg::NUM_HALF];
    logic [15:0] half_rd   [iowl_pkg::NUM_HALF];
    logic [15:0] rd_acc    [iowl_pkg::NUM_HALF+1];
    logic [iowl_pkg::NUM_HALF-1:0] half_sel;
    logic [31:0] win_bot   [iowl_pkg::NUM_WIN];
    logic [31:0] win_top   [iowl_pkg::NUM_WIN];
    logic [iowl_pkg::NUM_WIN-1:0] win_hit;
    logic        sel_irq;
    logic        sel_ctrl;
    logic        sel_status;
    logic        mapped;
    logic [31:0] next_prdata;
    logic [7:0]  irq_route;
    logic [1:0]  ctrl;
    logic        decode_on;
    logic        next_fwd;
    logic [iowl_pkg::NUM_WIN-1:0] next_fwd_win;
    logic [31:0] status_word;

    // bus decode
    assign reg_idx   = PADDR_I[iowl_pkg::IDX_MSB:iowl_pkg::IDX_LSB];
    assign setup_rd  = PSEL_I && !PENABLE_I && !PWRITE_I;
    assign access    = PSEL_I && PENABLE_I;
    assign wr_access = access && PWRITE_I;
    assign sel_irq   = (reg_idx == iowl_pkg::IDX_IRQ_ROUTE);
    assign sel_ctrl  = (reg_idx == iowl_pkg::IDX_CTRL);
    assign sel_status = (reg_idx == iowl_pkg::IDX_STATUS);
    // address bits 1..0 must be zero; only word-aligned offsets are mapped
    assign mapped    = ((|half_sel) || sel_irq || sel_ctrl || sel_status)
                       && (PADDR_I[1:0] == 2'h0);
    // zero wait states: read data is captured in the setup cycle
    assign PREADY_O  = 1'b1;
    assign PSLVERR_O = access && !mapped;
    assign mode_bits = IO_ADDR_32 ? iowl_pkg::MODE_32 : iowl_pkg::MODE_16;

    genvar gi;
    generate
        for (gi = 0; gi < iowl_pkg::NUM_HALF; gi++)
        begin : g_half
            localparam bit IS_LOW = (gi % 2) == 0;
            localparam logic [15:0] WM = IS_LOW ? iowl_pkg::LOW_WMASK
                                                : iowl_pkg::HIGH_WMASK;
            logic wr_en;

            assign half_sel[gi] = (reg_idx == iowl_pkg::HALF_IDX[gi]);
            // upper halves lock while only 16-bit addressing is built
            assign wr_en = wr_access && half_sel[gi]
                           && (IS_LOW || IO_ADDR_32);

            iowl_half_reg #(
                .WMASK (WM)
            ) u_half (
                .clk_i   (CLK_I),
                .reset_i (RESET_I),
                .wr_i    (wr_en),
                .be_i    (PSTRB_I[1:0]),
                .wdata_i (PWDATA_I[15:0]),
                .q_o     (half_q[gi])
            );

            // low halves report the addressing mode in bits 1..0
            assign half_rd[gi] = IS_LOW ? {half_q[gi][15:2], mode_bits}
                                        : half_q[gi];
            assign rd_acc[gi+1] = rd_acc[gi] | (half_sel[gi] ? half_rd[gi] : 16'h0000);
        end
    endgenerate
    assign rd_acc[0] = 16'h0000;

    generate
        for (gi = 0; gi < iowl_pkg::NUM_WIN; gi++)
        begin : g_win
            iowl_win_cmp u_cmp (
                .mode32_i (IO_ADDR_32),
                .addr_i   (IO_ADDR_I),
                .bot_lo_i (half_q[4*gi]),
                .bot_hi_i (half_q[4*gi+1]),
                .top_lo_i (half_q[4*gi+2]),
                .top_hi_i (half_q[4*gi+3]),
                .bot_o    (win_bot[gi]),
                .top_o    (win_top[gi]),
                .hit_o    (win_hit[gi])
            );
        end
    endgenerate

    // both windows share one enable; a 16-bit card disables them entirely
    assign decode_on    = ctrl[iowl_pkg::CTRL_IO_EN]
                          && ctrl[iowl_pkg::CTRL_CARD_CB];
    assign next_fwd_win = (IO_REQ_I && decode_on) ? win_hit
                                                  : '0;
    assign next_fwd     = |next_fwd_win;
    assign status_word  = {28'h0000000, IO_ADDR_32, FWD_WIN_O, FWD_O};

    assign next_prdata = sel_irq    ? {24'h000000, irq_route}
                       : sel_ctrl   ? {30'h0000000, ctrl}
                       : sel_status ? status_word
                       : {16'h0000, rd_acc[iowl_pkg::NUM_HALF]};

    always_ff @(posedge CLK_I)
    begin
        if (RESET_I)
            PRDATA_O <= 32'h00000000;
        else if (setup_rd)
            PRDATA_O <= next_prdata;
    end

    // routing number is storage only; software assigns its meaning
    always_ff @(posedge CLK_I)
    begin
        if (RESET_I)
            irq_route <= iowl_pkg::IRQ_RESET;
        else if (wr_access && sel_irq && PSTRB_I[0])
            irq_route <= PWDATA_I[7:0];
    end
    assign IRQ_ROUTE_O = irq_route;

    always_ff @(posedge CLK_I)
    begin
        if (RESET_I)
            ctrl <= iowl_pkg::CTRL_RESET;
        else if (wr_access && sel_ctrl && PSTRB_I[0])
            ctrl <= PWDATA_I[1:0];
    end

    // forwarding decision is registered: answer one edge after the request
    always_ff @(posedge CLK_I)
    begin
        if (RESET_I)
        begin
            FWD_O     <= 1'b0;
            FWD_WIN_O <= '0;
        end
        else
        begin
            FWD_O     <= next_fwd;
            FWD_WIN_O <= next_fwd_win;
        end
    end

    // checks
    default clocking cb_main @(posedge CLK_I);
    endclocking
    default disable iff (RESET_I);

    sequence s_wr_setup(logic [7:0] idx);
        PSEL_I && !PENABLE_I && PWRITE_I && reg_idx == idx;
    endsequence
    sequence s_wr_access(logic [7:0] idx);
        PSEL_I && PENABLE_I && PWRITE_I && reg_idx == idx;
    endsequence
    sequence s_rd_setup(logic [7:0] idx);
        PSEL_I && !PENABLE_I && !PWRITE_I && reg_idx == idx;
    endsequence

    a_fwd_needs_enable: assert property (
        FWD_O |-> $past(IO_REQ_I) && $past(ctrl[iowl_pkg::CTRL_IO_EN])
                  && $past(ctrl[iowl_pkg::CTRL_CARD_CB]))
        else $error("forward without io enable, cardbus card and request");

    a_fwd_in_window: assert property (
        IO_REQ_I && decode_on && (IO_ADDR_I >= win_bot[1])
            && (IO_ADDR_I <= win_top[1]) |=> FWD_O && FWD_WIN_O[1])
        else $error("address inside window 1 not forwarded");

    a_no_fwd_16card: assert property (
        !ctrl[iowl_pkg::CTRL_CARD_CB] |=> !FWD_O)
        else $error("forward while a 16-bit card is selected");

    a_low_mode_bits: assert property (
        PSEL_I && !PENABLE_I && !PWRITE_I && reg_idx == iowl_pkg::IDX_W1_TOP_LO
            |=> PRDATA_O[1:0] == (IO_ADDR_32 ? iowl_pkg::MODE_32 : iowl_pkg::MODE_16))
        else $error("low bound read lost the addressing mode bits");

    a_low_write: assert property (
        s_wr_setup(iowl_pkg::IDX_W0_TOP_LO) ##1
            (s_wr_access(iowl_pkg::IDX_W0_TOP_LO) ##0 PSTRB_I[1:0] == 2'h3)
            |=> half_q[2] == {$past(PWDATA_I[15:2]), 2'h0})
        else $error("low bound write did not store bits 15..2 only");

    a_upper_locked: assert property (
        !IO_ADDR_32 ##0 s_wr_access(iowl_pkg::IDX_W1_BOT_HI) |=> $stable(half_q[5]))
        else $error("upper bound changed in 16-bit mode");

    a_reset_zero: assert property (
        disable iff (1'b0)
        RESET_I |=> half_q[0] == 16'h0000 && half_q[3] == 16'h0000
                    && half_q[7] == 16'h0000 && !FWD_O)
        else $error("bound registers not cleared by reset");

    a_irq_write: assert property (
        s_wr_access(iowl_pkg::IDX_IRQ_ROUTE) ##0 PSTRB_I[0]
            |=> IRQ_ROUTE_O == $past(PWDATA_I[7:0])
                ##1 ($stable(IRQ_ROUTE_O) || $past(wr_access)))
        else $error("routing number write not stored");

    a_limit_incl: assert property (
        IO_REQ_I && decode_on && IO_ADDR_I == win_top[0]
            && win_bot[0] <= win_top[0] |=> FWD_WIN_O[0])
        else $error("last doubleword of window 0 not forwarded");

    a_upper_zero16: assert property (
        !IO_ADDR_32 |-> win_top[0][31:16] == 16'h0000 && win_bot[1][31:16] == 16'h0000)
        else $error("upper bound bits used in 16-bit mode");

    a_base0_upper16: assert property (
        !IO_ADDR_32 |-> win_bot[0][31:16] == 16'h0000 && win_top[1][31:16] == 16'h0000)
        else $error("upper edge bits of a window used in 16-bit mode");

    a_upper_used32: assert property (
        IO_ADDR_32 |-> win_bot[0][31:16] == half_q[1] && win_top[1][31:16] == half_q[7])
        else $error("upper bound register not used in 32-bit mode");

    a_low_ro_zero: assert property (
        half_q[0][1:0] == 2'h0 && half_q[2][1:0] == 2'h0
            && half_q[4][1:0] == 2'h0 && half_q[6][1:0] == 2'h0)
        else $error("read-only bits of a low bound were written");

    a_mode_bot0: assert property (
        s_rd_setup(iowl_pkg::IDX_W0_BOT_LO)
            |=> PRDATA_O[1:0] == (IO_ADDR_32 ? iowl_pkg::MODE_32 : iowl_pkg::MODE_16))
        else $error("window 0 base read lost the addressing mode bits");

    a_mode_top0: assert property (
        s_rd_setup(iowl_pkg::IDX_W0_TOP_LO)
            |=> PRDATA_O[1:0] == (IO_ADDR_32 ? iowl_pkg::MODE_32 : iowl_pkg::MODE_16))
        else $error("window 0 limit read lost the addressing mode bits");

    a_mode_bot1: assert property (
        s_rd_setup(iowl_pkg::IDX_W1_BOT_LO)
            |=> PRDATA_O[1:0] == (IO_ADDR_32 ? iowl_pkg::MODE_32 : iowl_pkg::MODE_16))
        else $error("window 1 base read lost the addressing mode bits");

    a_low_write_w1: assert property (
        s_wr_setup(iowl_pkg::IDX_W1_BOT_LO) ##1
            (s_wr_access(iowl_pkg::IDX_W1_BOT_LO) ##0 PSTRB_I[1:0] == 2'h3)
            |=> half_q[4] == {$past(PWDATA_I[15:2]), 2'h0})
        else $error("window 1 base write did not store bits 15..2 only");

    a_low_write_top1: assert property (
        s_wr_setup(iowl_pkg::IDX_W1_TOP_LO) ##1
            (s_wr_access(iowl_pkg::IDX_W1_TOP_LO) ##0 PSTRB_I[1:0] == 2'h3)
            |=> half_q[6] == {$past(PWDATA_I[15:2]), 2'h0})
        else $error("window 1 limit write did not store bits 15..2 only");

    a_upper_write32: assert property (
        IO_ADDR_32 ##0 s_wr_access(iowl_pkg::IDX_W0_TOP_HI) ##0 PSTRB_I[1:0] == 2'h3
            |=> half_q[3] == $past(PWDATA_I[15:0]))
        else $error("window 0 upper limit write lost in 32-bit mode");

    a_upper_write_bot1: assert property (
        IO_ADDR_32 ##0 s_wr_access(iowl_pkg::IDX_W1_BOT_HI) ##0 PSTRB_I[1:0] == 2'h3
            |=> half_q[5] == $past(PWDATA_I[15:0]))
        else $error("window 1 upper base write lost in 32-bit mode");

    a_upper_idle16: assert property (
        !IO_ADDR_32 |-> half_q[1] == 16'h0000 && half_q[3] == 16'h0000
                        && half_q[5] == 16'h0000 && half_q[7] == 16'h0000)
        else $error("upper bound not zero in 16-bit mode");

    a_upper_lock_top1: assert property (
        !IO_ADDR_32 ##0 s_wr_access(iowl_pkg::IDX_W1_TOP_HI) |=> $stable(half_q[7]))
        else $error("window 1 upper limit changed in 16-bit mode");

    a_no_fwd_io_off: assert property (
        !ctrl[iowl_pkg::CTRL_IO_EN] |=> !FWD_O && FWD_WIN_O == '0)
        else $error("forward while i/o space is disabled");

    a_no_win_16card: assert property (
        !ctrl[iowl_pkg::CTRL_CARD_CB] |=> FWD_WIN_O == '0)
        else $error("window hit while a 16-bit card is selected");

    a_no_fwd_idle: assert property (
        !IO_REQ_I |=> !FWD_O && FWD_WIN_O == '0)
        else $error("forward without an i/o request");

    a_fwd_any_win: assert property (
        FWD_O == (|FWD_WIN_O))
        else $error("forward flag disagrees with window hits");

    a_fwd_in_win0: assert property (
        IO_REQ_I && decode_on && IO_ADDR_I >= win_bot[0] && IO_ADDR_I <= win_top[0]
            |=> FWD_O && FWD_WIN_O[0])
        else $error("address inside window 0 not forwarded");

    a_outside_win0: assert property (
        IO_REQ_I && (IO_ADDR_I < win_bot[0] || IO_ADDR_I > win_top[0]) |=> !FWD_WIN_O[0])
        else $error("address outside window 0 forwarded");

    a_outside_win1: assert property (
        IO_REQ_I && (IO_ADDR_I < win_bot[1] || IO_ADDR_I > win_top[1]) |=> !FWD_WIN_O[1])
        else $error("address outside window 1 forwarded");

    a_limit_incl1: assert property (
        IO_REQ_I && decode_on && IO_ADDR_I == win_top[1]
            && win_bot[1] <= win_top[1] |=> FWD_WIN_O[1])
        else $error("last doubleword of window 1 not forwarded");

    a_irq_hold: assert property (
        !(wr_access && sel_irq) |=> $stable(IRQ_ROUTE_O))
        else $error("routing number changed without a write");

    a_irq_readback: assert property (
        s_rd_setup(iowl_pkg::IDX_IRQ_ROUTE) |=> PRDATA_O == {24'h000000, $past(irq_route)})
        else $error("routing number read back wrong");

    a_reset_rest: assert property (
        disable iff (1'b0)
        RESET_I |=> half_q[1] == 16'h0000 && half_q[2] == 16'h0000
                    && half_q[4] == 16'h0000 && half_q[5] == 16'h0000
                    && half_q[6] == 16'h0000 && IRQ_ROUTE_O == 8'h00 && FWD_WIN_O == '0)
        else $error("bound or routing registers not cleared by reset");
endmodule : iowl_regs

// [verification/iowl_io_host.sv]
// pci host side: presents i/o transaction addresses to the bridge
`timescale 1ns/1ps
module iowl_io_host (
    input  wire logic        clk_i,
    input  wire logic        go_i,
    input  wire logic [31:0] addr_i,
    output logic             io_req_o,
    output logic      [31:0] io_addr_o
);
    logic [31:0] last = 32'h0000_0000;
    always_ff @(posedge clk_i)
    begin
        if (go_i)
            last <= addr_i;
    end
    // outside a request the address bus shows junk, never the last value
    assign io_req_o  = go_i;
    assign io_addr_o = go_i ? addr_i : ~last;
endmodule : iowl_io_host

// [verification/io_window_limit_regs_tb.sv]
// self-checking bench for the i/o window and routing registers
`timescale 1ns/1ps
`define CHK(g, x) begin n_checks++; if ((g) !== (x)) begin n_mismatch++; \
    $display("[ERR] %0t got %0h exp %0h", $time, g, x); end end
module io_window_limit_regs_tb;
    logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, go = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, ioa = 32'h0, rd, io_addr, prdata;
    logic        err, io_req, pready, pslverr, fwd;
    logic [1:0]  fwd_win;
    logic [7:0]  irq;
    logic [31:0] rd16, prdata16;
    logic        err16, pready16, pslverr16, fwd16;
    logic [1:0]  fwd_win16;
    logic [7:0]  irq16;
    int          n_mismatch = 0, n_checks = 0, cyc = 0;
    iowl_regs #(.IO_ADDR_32(1'b1)) iowl_regs_inst (.CLK_I(clk), .RESET_I(rst),
        .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr),
        .PWDATA_I(pwdata), .PSTRB_I(4'hF), .PRDATA_O(prdata), .PREADY_O(pready),
        .PSLVERR_O(pslverr), .IO_REQ_I(io_req), .IO_ADDR_I(io_addr), .FWD_O(fwd),
        .FWD_WIN_O(fwd_win), .IRQ_ROUTE_O(irq));
    iowl_regs #(.IO_ADDR_32(1'b0)) iowl_regs_inst16 (.CLK_I(clk), .RESET_I(rst),
        .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr),
        .PWDATA_I(pwdata), .PSTRB_I(4'hF), .PRDATA_O(prdata16), .PREADY_O(pready16),
        .PSLVERR_O(pslverr16), .IO_REQ_I(io_req), .IO_ADDR_I(io_addr), .FWD_O(fwd16),
        .FWD_WIN_O(fwd_win16), .IRQ_ROUTE_O(irq16));
    iowl_io_host iowl_io_host_inst (.clk_i(clk), .go_i(go), .addr_i(ioa),
        .io_req_o(io_req), .io_addr_o(io_addr));
    initial forever #2.5 clk = ~clk;
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : end_of_test
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            n_mismatch++;
            end_of_test();
        end
    end
    task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1; pen <= 1'b0; pwr <= w; paddr <= {2'b00, idx, 2'b00}; pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do begin @(posedge clk); end while (pready !== 1'b1 || pready16 !== 1'b1);
        rd = prdata;
        rd16 = prdata16;
        err = pslverr;
        err16 = pslverr16;
        psel <= 1'b0; pen <= 1'b0;
    endtask : apb
    task automatic io(input logic [31:0] a, input logic [1:0] exp);
        @(posedge clk);
        go <= 1'b1; ioa <= a;
        @(posedge clk);
        go <= 1'b0;
        #1;
        `CHK(fwd_win, exp)
        `CHK(fwd, |exp)
    endtask : io
    task automatic t_reset_vals();
        for (int i = 0; i < iowl_pkg::NUM_HALF; i++)
        begin
            apb(1'b0, iowl_pkg::HALF_IDX[i], 32'h0);
            `CHK(rd, (i % 2 == 0) ? 32'h0000_0001 : 32'h0000_0000)
            `CHK(rd16, 32'h0000_0000)
        end
        apb(1'b0, iowl_pkg::IDX_IRQ_ROUTE, 32'h0);
        `CHK(rd, 32'h0000_0000)
        `CHK(rd16, 32'h0000_0000)
    endtask : t_reset_vals
    task automatic t_write_all();
        for (int i = 0; i < iowl_pkg::NUM_HALF; i++)
        begin
            apb(1'b1, iowl_pkg::HALF_IDX[i], 32'h0000_FFFF);
            apb(1'b0, iowl_pkg::HALF_IDX[i], 32'h0);
            `CHK(rd, (i % 2 == 0) ? 32'h0000_FFFD : 32'h0000_FFFF)
            `CHK(rd16, (i % 2 == 0) ? 32'h0000_FFFC : 32'h0000_0000)
        end
    endtask : t_write_all
    task automatic t_routing();
        apb(1'b1, iowl_pkg::IDX_IRQ_ROUTE, 32'hFFFF_FFA5);
        apb(1'b0, iowl_pkg::IDX_IRQ_ROUTE, 32'h0);
        `CHK(rd, 32'h0000_00A5)
        `CHK(irq, 8'hA5)
        `CHK(rd16, 32'h0000_00A5)
        `CHK(irq16, 8'hA5)
        apb(1'b1, 8'h80, 32'h0000_1234);
        `CHK(err, 1'b1)
        `CHK(err16, 1'b1)
        `CHK(irq, 8'hA5)
    endtask : t_routing
    task automatic t_forward();
        apb(1'b1, iowl_pkg::IDX_W0_BOT_LO, 32'h0000_1000);
        apb(1'b1, iowl_pkg::IDX_W0_BOT_HI, 32'h0000_0001);
        apb(1'b1, iowl_pkg::IDX_W0_TOP_LO, 32'h0000_10FC);
        apb(1'b1, iowl_pkg::IDX_W0_TOP_HI, 32'h0000_0001);
        apb(1'b1, iowl_pkg::IDX_W1_BOT_LO, 32'h0000_0000);
        apb(1'b1, iowl_pkg::IDX_W1_BOT_HI, 32'h0000_0002);
        apb(1'b1, iowl_pkg::IDX_W1_TOP_LO, 32'h0000_0000);
        apb(1'b1, iowl_pkg::IDX_W1_TOP_HI, 32'h0000_0002);
        apb(1'b1, iowl_pkg::IDX_CTRL, 32'h0000_0003);
        io(32'h0001_10FF, 2'b01);
        io(32'h0001_1100, 2'b00);
        io(32'h0001_1000, 2'b01);
        io(32'h0001_0FFF, 2'b00);
        io(32'h0002_0003, 2'b10);
        io(32'h0002_0004, 2'b00);
        io(32'h0000_10FF, 2'b00);
        `CHK(fwd_win16, 2'b01)
        io(32'h0000_0003, 2'b00);
        `CHK(fwd_win16, 2'b10)
        io(32'h0000_0004, 2'b00);
        `CHK(fwd16, 1'b0)
        apb(1'b1, iowl_pkg::IDX_CTRL, 32'h0000_0001);
        io(32'h0001_1000, 2'b00);
        io(32'h0000_1000, 2'b00);
        `CHK(fwd16, 1'b0)
        apb(1'b1, iowl_pkg::IDX_CTRL, 32'h0000_0002);
        io(32'h0002_0000, 2'b00);
        io(32'h0000_0000, 2'b00);
        `CHK(fwd16, 1'b0)
    endtask : t_forward
    initial
    begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        t_reset_vals();
        t_write_all();
        t_routing();
        t_forward();
        end_of_test();
    end
endmodule : io_window_limit_regs_tb
